// ### core/rtuslv_pkg.sv
package rtuslv_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYC = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int CHAR_BITS = 11;
  // Gaps in tenths of a character time.
  localparam int GAP_IN_X10 = 15;
  localparam int GAP_END_X10 = 35;
  localparam int T15_CYC = (BIT_CYC * CHAR_BITS * GAP_IN_X10 + 9) / 10;
  localparam int T35_CYC = (BIT_CYC * CHAR_BITS * GAP_END_X10 + 9) / 10;
  localparam int STOP_BIT = 10;

  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WR1 = 8'h06;
  localparam logic [7:0] FC_ECHO = 8'h08;
  localparam logic [7:0] FC_WRN = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VAL = 8'h03;
  localparam logic [16:0] MAP_WORDS = 17'h00020;
  localparam logic [15:0] MAX_RD = 16'h007d;
  localparam logic [15:0] MAX_WR = 16'h007b;
  localparam logic [8:0] FIXED_LEN = 9'h008;
  localparam logic [8:0] WRN_HDR = 9'h009;
  localparam logic [8:0] MIN_LEN = 9'h004;
  localparam logic [8:0] BUF_FULL = 9'h100;
  localparam logic [8:0] EXC_LEN = 9'h003;
  localparam logic [8:0] ECHO_LEN = 9'h006;
  localparam logic [7:0] WDATA_FIRST = 8'h07;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  typedef enum logic [3:0] {
    ST_SYNC, ST_IDLE, ST_RECV, ST_CHECK, ST_WRITE, ST_FETCH, ST_FWAIT, ST_SEND, ST_SENDW
  } rtuslv_state_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ### core/rtuslv_uart.sv
module rtuslv_uart #(
  parameter int BIT_CYC = rtuslv_pkg::BIT_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_rx,
  output logic o_rx_busy,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_err,
  input wire logic i_tx_start,
  input wire logic [7:0] i_tx_data,
  output logic o_tx,
  output logic o_tx_done
);
  localparam logic [15:0] BIT_M1 = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_M1 = 16'(BIT_CYC / 2 - 1);
  localparam logic [3:0] LAST_BIT = 4'(rtuslv_pkg::STOP_BIT);

  logic rx_act_q, rx_act_d, rx_val_q, rx_val_d, rx_err_q, rx_err_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [8:0] rx_sh_q, rx_sh_d;

  always_comb begin
    rx_act_d = rx_act_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_val_d = 1'b0;
    rx_err_d = rx_err_q;
    if (!rx_act_q) begin
      if (!i_rx) begin
        rx_act_d = 1'b1;
        rx_cnt_d = HALF_M1;
        rx_bit_d = 4'h0;
      end
    end else if (rx_cnt_q != 16'h0000) begin
      rx_cnt_d = rx_cnt_q - 16'h0001;
    end else begin
      rx_cnt_d = BIT_M1;
      rx_bit_d = rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0) begin
        // A start bit shorter than half a bit is taken as line noise.
        rx_act_d = !i_rx;
      end else if (rx_bit_q == LAST_BIT) begin
        rx_act_d = 1'b0;
        rx_val_d = 1'b1;
        rx_err_d = (^rx_sh_q) | !i_rx;
      end else begin
        rx_sh_d = {i_rx, rx_sh_q[8:1]};
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_val_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else begin
      rx_act_q <= rx_act_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_val_q <= rx_val_d;
      rx_err_q <= rx_err_d;
    end
  end

  assign o_rx_busy = rx_act_q;
  assign o_rx_valid = rx_val_q;
  assign o_rx_data = rx_sh_q[7:0];
  assign o_rx_err = rx_err_q;

  logic tx_act_q, tx_act_d, line_q, line_d, done_q, done_d;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [10:0] tx_sh_q, tx_sh_d;

  always_comb begin
    tx_act_d = tx_act_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    done_d = 1'b0;
    if (!tx_act_q) begin
      if (i_tx_start) begin
        tx_act_d = 1'b1;
        tx_cnt_d = BIT_M1;
        tx_bit_d = 4'h0;
        tx_sh_d = {1'b1, ^i_tx_data, i_tx_data, 1'b0};
      end
    end else if (tx_cnt_q != 16'h0000) begin
      tx_cnt_d = tx_cnt_q - 16'h0001;
    end else if (tx_bit_q == LAST_BIT) begin
      tx_act_d = 1'b0;
      done_d = 1'b1;
    end else begin
      tx_cnt_d = BIT_M1;
      tx_bit_d = tx_bit_q + 4'h1;
      tx_sh_d = {1'b1, tx_sh_q[10:1]};
    end
    line_d = tx_act_d ? tx_sh_d[0] : 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_act_q <= 1'b0;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
      line_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      tx_act_q <= tx_act_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      line_q <= line_d;
      done_q <= done_d;
    end
  end

  assign o_tx = line_q;
  assign o_tx_done = done_q;

  a_parity_check: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rx_act_q && rx_cnt_q == 16'h0000 && rx_bit_q == LAST_BIT) |=>
    (rx_val_q && rx_err_q == ((^$past(rx_sh_q)) | !$past(i_rx))))
    else $error("Receive parity or stop check wrong.");
  a_bit_period: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($changed(line_q) && tx_act_q) |-> (tx_cnt_q == BIT_M1))
    else $error("Transmit bit does not last one bit time.");
endmodule

// ### core/rtuslv_top.sv
module rtuslv_top #(
  parameter int P_BIT_CYC = rtuslv_pkg::BIT_CYC,
  parameter int P_T15 = rtuslv_pkg::T15_CYC,
  parameter int P_T35 = rtuslv_pkg::T35_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_rx,
  input wire logic [7:0] i_station_addr,
  output logic o_tx,
  output logic o_tx_en,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [15:0] o_reg_addr,
  output logic [15:0] o_reg_wdata,
  input wire logic [15:0] i_reg_rdata
);
  localparam logic [23:0] T15 = 24'(P_T15);
  localparam logic [23:0] T35 = 24'(P_T35);

  logic rx_busy, rx_valid, rx_err, tx_done;
  logic [7:0] rx_data;
  logic [7:0] fbuf_q [256];
  logic buf_we;
  logic [7:0] buf_wa;

  rtuslv_pkg::rtuslv_state_t st_q, st_d;
  logic [23:0] idle_q, idle_d;
  logic gap_q, gap_d, bad_q, bad_d, fq_q, fq_d;
  logic [8:0] len_q, len_d, idx_q, idx_d, rlen_q, rlen_d;
  logic [15:0] crc_q, crc_d, txcrc_q, txcrc_d, ptr_q, ptr_d, rd_q, rd_d;
  logic [7:0] exc_q, exc_d, wleft_q, wleft_d, wi_q, wi_d;
  logic tx_start_q, tx_start_d, tx_en_q, tx_en_d, reg_rd_q, reg_rd_d, reg_wr_q, reg_wr_d;
  logic [7:0] tx_byte_q, tx_byte_d;
  logic [15:0] reg_addr_q, reg_addr_d, reg_wdata_q, reg_wdata_d;

  logic [7:0] fc, nby, src;
  logic [15:0] start, cnt;
  logic [16:0] end_sum;
  logic own_ok, hit, bcast, good, need_fetch;
  logic [7:0] exc_c;
  logic [8:0] rlen_c;

  rtuslv_uart #(.BIT_CYC(P_BIT_CYC)) u_uart (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_rx(i_rx),
    .o_rx_busy(rx_busy),
    .o_rx_valid(rx_valid),
    .o_rx_data(rx_data),
    .o_rx_err(rx_err),
    .i_tx_start(tx_start_q),
    .i_tx_data(tx_byte_q),
    .o_tx(o_tx),
    .o_tx_done(tx_done)
  );

  // Request decode, always from the buffered frame.
  always_comb begin
    fc = fbuf_q[1];
    start = {fbuf_q[2], fbuf_q[3]};
    cnt = {fbuf_q[4], fbuf_q[5]};
    nby = fbuf_q[6];
    end_sum = {1'b0, start} + {1'b0, cnt};
    own_ok = i_station_addr >= rtuslv_pkg::ADDR_MIN && i_station_addr <= rtuslv_pkg::ADDR_MAX;
    hit = own_ok && fbuf_q[0] == i_station_addr;
    bcast = fbuf_q[0] == rtuslv_pkg::ADDR_BCAST;
    good = !bad_q && len_q >= rtuslv_pkg::MIN_LEN && crc_q == 16'h0000;
    exc_c = rtuslv_pkg::EXC_NONE;
    case (fc)
      rtuslv_pkg::FC_READ: begin
        if (len_q != rtuslv_pkg::FIXED_LEN || cnt == 16'h0000 || cnt > rtuslv_pkg::MAX_RD) begin
          exc_c = rtuslv_pkg::EXC_VAL;
        end else if (end_sum > rtuslv_pkg::MAP_WORDS) begin
          exc_c = rtuslv_pkg::EXC_ADDR;
        end
      end
      rtuslv_pkg::FC_WR1: begin
        if (len_q != rtuslv_pkg::FIXED_LEN) begin
          exc_c = rtuslv_pkg::EXC_VAL;
        end else if ({1'b0, start} >= rtuslv_pkg::MAP_WORDS) begin
          exc_c = rtuslv_pkg::EXC_ADDR;
        end
      end
      rtuslv_pkg::FC_ECHO: begin
        if (len_q != rtuslv_pkg::FIXED_LEN || start != 16'h0000) begin
          exc_c = rtuslv_pkg::EXC_VAL;
        end
      end
      rtuslv_pkg::FC_WRN: begin
        if (len_q != rtuslv_pkg::WRN_HDR + {1'b0, nby} || cnt == 16'h0000 || cnt > rtuslv_pkg::MAX_WR
            || {8'h00, nby} != {cnt[14:0], 1'b0}) begin
          exc_c = rtuslv_pkg::EXC_VAL;
        end else if (end_sum > rtuslv_pkg::MAP_WORDS) begin
          exc_c = rtuslv_pkg::EXC_ADDR;
        end
      end
      default: exc_c = rtuslv_pkg::EXC_FUNC;
    endcase
    if (exc_c != rtuslv_pkg::EXC_NONE) begin
      rlen_c = rtuslv_pkg::EXC_LEN;
    end else if (fc == rtuslv_pkg::FC_READ) begin
      rlen_c = rtuslv_pkg::EXC_LEN + {cnt[7:0], 1'b0};
    end else begin
      rlen_c = rtuslv_pkg::ECHO_LEN;
    end
  end

  // Byte to send at position idx_q of the response.
  always_comb begin
    need_fetch = exc_q == rtuslv_pkg::EXC_NONE && fc == rtuslv_pkg::FC_READ && idx_q >= 9'h003
                 && idx_q < rlen_q && idx_q[0];
    if (idx_q == rlen_q) begin
      src = txcrc_q[7:0];
    end else if (idx_q > rlen_q) begin
      src = txcrc_q[15:8];
    end else if (idx_q == 9'h000) begin
      src = fbuf_q[0];
    end else if (exc_q != rtuslv_pkg::EXC_NONE) begin
      src = (idx_q == 9'h001) ? (fc | rtuslv_pkg::EXC_FLAG) : exc_q;
    end else if (fc == rtuslv_pkg::FC_READ && idx_q >= 9'h002) begin
      src = (idx_q == 9'h002) ? {cnt[6:0], 1'b0} : (idx_q[0] ? rd_q[15:8] : rd_q[7:0]);
    end else begin
      src = fbuf_q[idx_q[7:0]];
    end
  end

  always_comb begin
    st_d = st_q;
    gap_d = gap_q;
    bad_d = bad_q;
    fq_d = fq_q;
    len_d = len_q;
    idx_d = idx_q;
    rlen_d = rlen_q;
    crc_d = crc_q;
    txcrc_d = txcrc_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    exc_d = exc_q;
    wleft_d = wleft_q;
    wi_d = wi_q;
    tx_en_d = tx_en_q;
    tx_byte_d = tx_byte_q;
    reg_addr_d = reg_addr_q;
    reg_wdata_d = reg_wdata_q;
    tx_start_d = 1'b0;
    reg_rd_d = 1'b0;
    reg_wr_d = 1'b0;
    buf_we = 1'b0;
    buf_wa = len_q[7:0];
    // Silence is counted only while neither end is on the line.
    idle_d = (rx_busy || tx_en_q) ? 24'h000000 : ((idle_q > T35) ? idle_q : idle_q + 24'h000001);
    case (st_q)
      rtuslv_pkg::ST_SYNC: begin
        if (idle_q > T35) begin
          st_d = rtuslv_pkg::ST_IDLE;
        end
      end
      rtuslv_pkg::ST_IDLE: begin
        if (rx_valid) begin
          buf_we = 1'b1;
          buf_wa = 8'h00;
          len_d = 9'h001;
          crc_d = rtuslv_pkg::crc_byte(rtuslv_pkg::CRC_INIT, rx_data);
          bad_d = rx_err;
          gap_d = 1'b0;
          st_d = rtuslv_pkg::ST_RECV;
        end
      end
      rtuslv_pkg::ST_RECV: begin
        if (rx_valid) begin
          // Frames longer than the buffer are dropped rather than truncated.
          buf_we = len_q != rtuslv_pkg::BUF_FULL;
          len_d = buf_we ? len_q + 9'h001 : len_q;
          crc_d = rtuslv_pkg::crc_byte(crc_q, rx_data);
          bad_d = bad_q | rx_err | gap_q | !buf_we;
        end
        if (idle_q > T15) begin
          gap_d = 1'b1;
        end
        if (idle_q > T35) begin
          st_d = rtuslv_pkg::ST_CHECK;
        end
      end
      rtuslv_pkg::ST_CHECK: begin
        exc_d = exc_c;
        rlen_d = rlen_c;
        idx_d = 9'h000;
        fq_d = 1'b0;
        ptr_d = start;
        wi_d = rtuslv_pkg::WDATA_FIRST;
        wleft_d = (fc == rtuslv_pkg::FC_WR1) ? 8'h01 : cnt[7:0];
        txcrc_d = rtuslv_pkg::CRC_INIT;
        if (!good || !(hit || bcast)) begin
          st_d = rtuslv_pkg::ST_IDLE;
        end else if (exc_c == rtuslv_pkg::EXC_NONE && (fc == rtuslv_pkg::FC_WR1 || fc == rtuslv_pkg::FC_WRN)) begin
          st_d = rtuslv_pkg::ST_WRITE;
        end else begin
          st_d = bcast ? rtuslv_pkg::ST_IDLE : rtuslv_pkg::ST_SEND;
        end
      end
      rtuslv_pkg::ST_WRITE: begin
        reg_wr_d = 1'b1;
        reg_addr_d = ptr_q;
        reg_wdata_d = (fc == rtuslv_pkg::FC_WR1) ? cnt : {fbuf_q[wi_q], fbuf_q[wi_q + 8'h01]};
        ptr_d = ptr_q + 16'h0001;
        wi_d = wi_q + 8'h02;
        wleft_d = wleft_q - 8'h01;
        if (wleft_q == 8'h01) begin
          st_d = bcast ? rtuslv_pkg::ST_IDLE : rtuslv_pkg::ST_SEND;
        end
      end
      rtuslv_pkg::ST_FETCH: begin
        reg_rd_d = 1'b1;
        reg_addr_d = ptr_q;
        st_d = rtuslv_pkg::ST_FWAIT;
      end
      rtuslv_pkg::ST_FWAIT: begin
        rd_d = i_reg_rdata;
        ptr_d = ptr_q + 16'h0001;
        fq_d = 1'b1;
        st_d = rtuslv_pkg::ST_SEND;
      end
      rtuslv_pkg::ST_SEND: begin
        if (idx_q == rlen_q + 9'h002) begin
          tx_en_d = 1'b0;
          st_d = rtuslv_pkg::ST_SYNC;
        end else if (need_fetch && !fq_q) begin
          st_d = rtuslv_pkg::ST_FETCH;
        end else begin
          tx_start_d = 1'b1;
          tx_byte_d = src;
          tx_en_d = 1'b1;
          fq_d = 1'b0;
          txcrc_d = (idx_q < rlen_q) ? rtuslv_pkg::crc_byte(txcrc_q, src) : txcrc_q;
          st_d = rtuslv_pkg::ST_SENDW;
        end
      end
      rtuslv_pkg::ST_SENDW: begin
        if (tx_done) begin
          idx_d = idx_q + 9'h001;
          st_d = rtuslv_pkg::ST_SEND;
        end
      end
      default: st_d = rtuslv_pkg::ST_SYNC;
    endcase
  end

  // The frame buffer holds data only, so it carries no reset.
  always_ff @(posedge i_ref_clk) begin
    if (buf_we) begin
      fbuf_q[buf_wa] <= rx_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= rtuslv_pkg::ST_SYNC;
      idle_q <= 24'h000000;
      gap_q <= 1'b0;
      bad_q <= 1'b0;
      fq_q <= 1'b0;
      len_q <= 9'h000;
      idx_q <= 9'h000;
      rlen_q <= 9'h000;
      crc_q <= rtuslv_pkg::CRC_INIT;
      txcrc_q <= rtuslv_pkg::CRC_INIT;
      ptr_q <= 16'h0000;
      rd_q <= 16'h0000;
      exc_q <= 8'h00;
      wleft_q <= 8'h00;
      wi_q <= 8'h00;
      tx_start_q <= 1'b0;
      tx_en_q <= 1'b0;
      tx_byte_q <= 8'h00;
      reg_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_addr_q <= 16'h0000;
      reg_wdata_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      idle_q <= idle_d;
      gap_q <= gap_d;
      bad_q <= bad_d;
      fq_q <= fq_d;
      len_q <= len_d;
      idx_q <= idx_d;
      rlen_q <= rlen_d;
      crc_q <= crc_d;
      txcrc_q <= txcrc_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      exc_q <= exc_d;
      wleft_q <= wleft_d;
      wi_q <= wi_d;
      tx_start_q <= tx_start_d;
      tx_en_q <= tx_en_d;
      tx_byte_q <= tx_byte_d;
      reg_rd_q <= reg_rd_d;
      reg_wr_q <= reg_wr_d;
      reg_addr_q <= reg_addr_d;
      reg_wdata_q <= reg_wdata_d;
    end
  end

  assign o_tx_en = tx_en_q;
  assign o_reg_rd = reg_rd_q;
  assign o_reg_wr = reg_wr_q;
  assign o_reg_addr = reg_addr_q;
  assign o_reg_wdata = reg_wdata_q;

  a_end_silence: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_RECV && idle_q > T35) |=> (st_q == rtuslv_pkg::ST_CHECK))
    else $error("Frame end not taken after long silence.");
  a_gap_discard: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_RECV && gap_q && rx_valid) |=> bad_q)
    else $error("Character after long gap did not spoil the frame.");
  a_drop_bad: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_CHECK && (!good || !(hit || bcast))) |=> (st_q == rtuslv_pkg::ST_IDLE))
    else $error("Bad or foreign frame was not dropped.");
  a_bcast_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_CHECK && bcast) |=> (!tx_start_q && st_q != rtuslv_pkg::ST_SEND) [*8])
    else $error("Broadcast request got a response.");
  a_own_range: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_CHECK && hit) |-> (fbuf_q[0] != rtuslv_pkg::ADDR_BCAST && fbuf_q[0] <= 8'hf7))
    else $error("Station address out of range was accepted.");
  a_resp_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_SEND && idx_q == 9'h000) |=> (tx_start_q && tx_byte_q == i_station_addr))
    else $error("Response does not start with own address.");
  a_exc_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_SEND && exc_q != 8'h00 && idx_q == 9'h001) |=>
    (tx_start_q && tx_byte_q == (fbuf_q[1] | 8'h80)))
    else $error("Exception function code not flagged.");
  a_bad_func: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_CHECK && !(fc inside {8'h03, 8'h06, 8'h08, 8'h10})) |=> (exc_q == 8'h01))
    else $error("Unsupported function not refused.");
  a_read_count: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_SEND && exc_q == 8'h00 && fc == 8'h03 && idx_q == 9'h002) |=>
    (tx_byte_q == {cnt[6:0], 1'b0}))
    else $error("Read byte count wrong.");
  a_crc_order: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_SEND && idx_q == rlen_q) |=> (tx_byte_q == $past(txcrc_q[7:0])))
    else $error("Checksum low byte not sent first.");
  a_echo_same: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_q == rtuslv_pkg::ST_SEND && exc_q == 8'h00 && fc != 8'h03 && idx_q < 9'h006) |=>
    (tx_byte_q == fbuf_q[$past(idx_q[7:0])]))
    else $error("Echoed field differs from request.");
endmodule

// ### sim/rtuslv_master.sv
module rtuslv_master #(
  parameter int BIT_CYC = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_tx,
  input wire logic i_tx_en,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q[$];
  int frame_errs = 0;
  int gap_errs = 0;
  initial o_line = 1'b1;
  // Sends one character at the fixed bit time, then idles gap cycles.
  task automatic send_byte(input logic [7:0] b, input int gap);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_line = f[i];
      repeat (BIT_CYC) @(posedge i_ref_clk);
      #1;
    end
    if (gap > 0) begin
      repeat (gap) @(posedge i_ref_clk);
      #1;
    end
  endtask
  // Listens only while the driver is enabled, as a real transceiver would.
  always begin : rx_proc
    logic [10:0] f;
    int n;
    // The line is sampled on the falling edge, away from the edge that moves it.
    @(negedge i_ref_clk iff (i_tx === 1'b0 && i_tx_en === 1'b1));
    repeat (BIT_CYC / 2) @(negedge i_ref_clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = i_tx;
      if (i < 10) repeat (BIT_CYC) @(negedge i_ref_clk);
    end
    if (f[0] !== 1'b0 || f[10] !== 1'b1 || ^f[9:1] !== 1'b0) frame_errs++;
    rx_q.push_back(f[8:1]);
    n = 0;
    while (i_tx === 1'b1 && i_tx_en === 1'b1 && n < BIT_CYC) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n == BIT_CYC) gap_errs++;
  end
endmodule

// ### sim/test_rtuslv_top.sv
module test_rtuslv_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, rx, tx, tx_en, rd, wr;
  logic [7:0] sa = 8'h01;
  logic [15:0] ra, wd, rdata;
  logic [15:0] mem[32];
  logic [31:0] wq[$];
  logic [15:0] rq[$];
  int bad_count = 0, total_checks = 0;
  initial forever #5 clk = ~clk;
  assign rdata = mem[ra[4:0]];
  rtuslv_top #(.P_BIT_CYC(16), .P_T15(264), .P_T35(616)) i_rtuslv_top (.i_ref_clk(clk), .i_rst(rst),
    .i_rx(rx), .i_station_addr(sa), .o_tx(tx), .o_tx_en(tx_en), .o_reg_rd(rd), .o_reg_wr(wr),
    .o_reg_addr(ra), .o_reg_wdata(wd), .i_reg_rdata(rdata));
  rtuslv_master #(.BIT_CYC(16)) i_rtuslv_master (.i_ref_clk(clk), .i_tx(tx), .i_tx_en(tx_en), .o_line(rx));
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Strobes are looked at mid-cycle, where they are settled.
  always @(negedge clk) begin
    if (wr === 1'b1) begin
      if (wq.size() == 0) check("reg_write_extra", 0, 1);
      else check("reg_write", wq.pop_front(), {ra, wd});
    end
    if (rd === 1'b1) begin
      if (rq.size() == 0) check("reg_read_extra", 0, 1);
      else check("reg_read", rq.pop_front(), ra);
    end
  end
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // Model of the slave: works out the reply and the register writes for one request.
  task automatic xact(input logic [7:0] b[$], input int gap_at, input logic [7:0] bad);
    logic [7:0] r[$], q[$];
    logic [15:0] c;
    int st, n, code, ok, k;
    st = {b[2], b[3]};
    n = {b[4], b[5]};
    code = 0;
    ok = bad == 0 && gap_at < 0 && ((b[0] == sa && sa >= 1 && sa <= 247) || b[0] == 0);
    case (b[1])
      8'h03: if (b.size() != 6 || n < 1 || n > 125) code = 3; else if (st + n > 32) code = 2;
        else begin
          r = {sa, 8'h03, 8'(2 * n)};
          for (k = 0; k < n; k++) begin
            r = {r, mem[st + k][15:8], mem[st + k][7:0]};
            if (ok && b[0] != 0) rq.push_back(16'(st + k));
          end
        end
      8'h06: if (b.size() != 6) code = 3; else if (st >= 32) code = 2;
        else begin
          r = b;
          if (ok) wq.push_back({16'(st), 16'(n)});
          if (ok) mem[st] = 16'(n);
        end
      8'h08: if (b.size() != 6 || b[2] != 0 || b[3] != 0) code = 3; else r = b;
      8'h10: if (b.size() != 7 + 2 * n || n < 1 || n > 123 || b[6] != 2 * n) code = 3;
        else if (st + n > 32) code = 2;
        else begin
          r = b[0:5];
          for (k = 0; k < n && ok; k++) begin
            wq.push_back({16'(st + k), b[7 + 2 * k], b[8 + 2 * k]});
            mem[st + k] = {b[7 + 2 * k], b[8 + 2 * k]};
          end
        end
      default: code = 1;
    endcase
    if (code != 0) r = {sa, b[1] | 8'h80, 8'(code)};
    if (!ok || b[0] == 0) r = {};
    c = crc(r);
    if (r.size() > 0) r = {r, c[7:0], c[15:8]};
    c = crc(b);
    q = {b, c[7:0] ^ bad, c[15:8]};
    foreach (q[i]) i_rtuslv_master.send_byte(q[i], i == gap_at ? 300 : 0);
    for (k = 0; k < 4000 && i_rtuslv_master.rx_q.size() < r.size(); k++) @(posedge clk);
    repeat (1300) @(posedge clk);
    #1;
    check("reply_len", r.size(), i_rtuslv_master.rx_q.size());
    foreach (r[i]) if (i_rtuslv_master.rx_q.size() > 0) check("reply_byte", r[i], i_rtuslv_master.rx_q.pop_front());
    i_rtuslv_master.rx_q = {};
    check("writes_left", 0, wq.size());
    check("reads_left", 0, rq.size());
    wq = {};
    rq = {};
  endtask
  initial begin
    logic [7:0] d[4];
    void'($urandom(97389));
    sa = 8'($urandom_range(247, 1));
    foreach (mem[i]) mem[i] = 16'($urandom);
    foreach (d[i]) d[i] = 8'($urandom);
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (700) @(posedge clk);
    #1;
    xact({sa, 8'h10, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, d[0], d[1], d[2], d[3]}, -1, 0);
    xact({sa, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02}, -1, 0);
    xact({sa, 8'h03, 8'h00, 8'h1f, 8'h00, 8'h01}, -1, 0);
    xact({sa, 8'h03, 8'h00, 8'h1f, 8'h00, 8'h02}, -1, 0);
    xact({sa, 8'h06, 8'h00, 8'h07, d[2], d[0]}, -1, 0);
    xact({sa, 8'h08, 8'h00, 8'h00, d[1], d[3]}, -1, 0);
    xact({sa, 8'h08, 8'h01, 8'h00, d[1], d[3]}, -1, 0);
    xact({sa, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, -1, 0);
    xact({8'h00, 8'h06, 8'h00, 8'h09, d[3], d[2]}, -1, 0);
    xact({sa, 8'h03, 8'h00, 8'h09, 8'h00, 8'h01}, -1, 0);
    xact({8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, -1, 0);
    xact({sa, 8'h06, 8'h00, 8'h03, d[0], d[1]}, -1, 8'h5a);
    xact({sa + 8'h01, 8'h06, 8'h00, 8'h03, d[0], d[1]}, -1, 0);
    xact({sa, 8'h06, 8'h00, 8'h03, d[0], d[1]}, 2, 0);
    xact({sa, 8'h06, 8'h00, 8'h20, d[0], d[1]}, -1, 0);
    xact({sa, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, d[0], d[1]}, -1, 0);
    // An own address above the legal range must make the block ignore requests sent to that address.
    sa = 8'hf8;
    xact({sa, 8'h06, 8'h00, 8'h03, d[0], d[1]}, -1, 0);
    check("tx_char_gaps", 0, i_rtuslv_master.gap_errs);
    check("tx_char_frame", 0, i_rtuslv_master.frame_errs);
    end_sim();
  end
endmodule
